// >>> verilog/ddrb_defines.svh
// Shared constants for the DRAM bank, row and burst link.
// Assumes a 100 MHz system clock on both ends of the link.
`ifndef DDRB_DEFINES_SVH
`define DDRB_DEFINES_SVH
// Address line positions
`define DDRB_AP_BIT 10
`define DDRB_BLSEL_BIT 12
`define DDRB_COL_SEL_BIT 3
`define DDRB_MR_BL_HI 1
`define DDRB_MR_BL_LO 0
// Burst length field of mode register zero
`define DDRB_MR_BL_FIX8 2'h0
`define DDRB_MR_BL_OTF 2'h1
// Beat counts and spacing
`define DDRB_BEATS8 4'h8
`define DDRB_BEATS4 4'h4
`define DDRB_CCD_CK 4'h4
`define DDRB_WR_SLACK 5'h02
`define DDRB_AP_MARGIN 8'h04
// Link clock timing
`define DDRB_SYS_PERIOD_NS 10
`define DDRB_CK_HALF_NS 80
`define DDRB_CK_HALF_CYC (`DDRB_CK_HALF_NS / `DDRB_SYS_PERIOD_NS)
`endif

// >>> verilog/ddrb_pkg.sv
// Types shared by both ends of the DRAM link.
// Assumes ddrb_defines.svh is on the include path.
`include "ddrb_defines.svh"
package ddrb_pkg;
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_ACT = 3'h1,
    CMD_PRE = 3'h2,
    CMD_RD = 3'h3,
    CMD_WR = 3'h4,
    CMD_MRS = 3'h5
  } ddrb_cmd_e;
  typedef enum logic [1:0] {
    DS_IDLE = 2'h0,
    DS_WAIT = 2'h1,
    DS_XFER = 2'h3,
    DS_DONE = 2'h2
  } ddrb_dev_e;
  typedef enum logic [2:0] {
    CS_INIT = 3'h4,
    CS_IDLE = 3'h0,
    CS_SEND = 3'h1,
    CS_DATA = 3'h3,
    CS_GAP = 3'h2
  } ddrb_ctl_e;
  // Eight beats for fixed eight, or on the fly with the select bit high
  function automatic logic ddrb_bl8(input logic [1:0] mr_bl,
                                    input logic sel);
    ddrb_bl8 = (mr_bl == `DDRB_MR_BL_FIX8) ||
               ((mr_bl == `DDRB_MR_BL_OTF) && sel);
  endfunction : ddrb_bl8
endpackage : ddrb_pkg

// >>> verilog/ddrb_link_if.sv
// Link between controller end and memory end.
// Resolves the shared data and strobe wires from the enables.
`timescale 1ns/10ps
interface ddrb_link_if;
  logic ck;
  logic [2:0] cmd;
  logic [2:0] bank_select_lines;
  logic [15:0] row_address_lines;
  logic [7:0] ctl_dq_o, dev_dq_o, dq;
  logic ctl_dq_oe_n, dev_dq_oe_n;
  logic ctl_dqs_o, dev_dqs_o, dqs;
  logic ctl_dqs_oe_n, dev_dqs_oe_n;
  // Undriven wires read low, as a pull-down would give
  assign dq = !dev_dq_oe_n ? dev_dq_o :
              (!ctl_dq_oe_n ? ctl_dq_o : 8'h00);
  assign dqs = !dev_dqs_oe_n ? dev_dqs_o :
               (!ctl_dqs_oe_n ? ctl_dqs_o : 1'b0);
  modport ctl (output ck, cmd, bank_select_lines, row_address_lines,
               ctl_dq_o, ctl_dq_oe_n, ctl_dqs_o, ctl_dqs_oe_n,
               input dq, dqs);
  modport dev (input ck, cmd, bank_select_lines, row_address_lines,
               dq, dqs,
               output dev_dq_o, dev_dq_oe_n, dev_dqs_o, dev_dqs_oe_n);
endinterface : ddrb_link_if

// >>> verilog/ddrb_sync3.sv
// Three-stage synchroniser with change pulses.
// Assumes d comes from outside the CLK_SYS domain.
`timescale 1ns/10ps
module ddrb_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q,
  output logic [W-1:0] chg
);
  logic [W-1:0] s1_reg, s2_reg, s3_reg;
  // Change accepted only once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q <= '0;
      chg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
          chg[i] <= s3_reg[i] ^ q[i];
        end else begin
          chg[i] <= 1'b0;
        end
      end
    end
  end
endmodule : ddrb_sync3

// >>> verilog/ddrb_dev_end.sv
// Memory end of the link: bank rows, precharge, bursts and storage.
// Assumes the controller end keeps its own command timing.
`timescale 1ns/10ps
`include "ddrb_defines.svh"
module ddrb_dev_end #(
  parameter int CL = 5,
  parameter int AL = 0,
  parameter int CWL = 5,
  parameter int RP_CK = 4,
  parameter int IDX_BITS = 1
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Link to the controller
  ddrb_link_if.dev LINK,
  // Bank status
  output logic [7:0] BANK_OPEN
);
  import ddrb_pkg::*;
  localparam int IW = IDX_BITS + 4;
  localparam int NWORD = 2 ** (IW + 3);
  localparam logic [5:0] RL = 6'(AL + CL);
  localparam logic [5:0] WL = 6'(AL + CWL);
  localparam logic [7:0] RP = 8'(RP_CK);

  logic [22:0] ca_q, ca_chg;
  logic [8:0] dw_q, dw_chg;
  ddrb_cmd_e cmd_c;
  logic [2:0] ba_c;
  logic [15:0] ad_c;
  logic ck_rise, ck_edge, dqs_edge;

  // Command, address and link clock cross in together
  ddrb_sync3 #(.W(23)) u_ca_sync (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .d({LINK.ck, LINK.cmd, LINK.bank_select_lines,
        LINK.row_address_lines}),
    .q(ca_q),
    .chg(ca_chg)
  );
  // Strobe and data share stages so they stay aligned
  ddrb_sync3 #(.W(9)) u_dw_sync (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .d({LINK.dqs, LINK.dq}),
    .q(dw_q),
    .chg(dw_chg)
  );

  assign cmd_c = ddrb_cmd_e'(ca_q[21:19]);
  assign ba_c = ca_q[18:16];
  assign ad_c = ca_q[15:0];
  assign ck_rise = ca_chg[22] && ca_q[22];
  assign ck_edge = ca_chg[22];
  assign dqs_edge = dw_chg[8];

  logic [7:0] open_reg;
  logic [15:0] row_reg [8];
  logic [7:0] rp_reg [8];
  logic [1:0] mr_bl_reg;
  ddrb_dev_e st_reg;
  logic is_wr_reg, ap_reg;
  logic [3:0] beats_reg, wcnt_reg;
  logic [2:0] bank_reg;
  logic [IW-1:0] idx_reg;
  logic [5:0] lat_reg;
  logic [4:0] edge_reg;
  logic [7:0] mem [NWORD];
  logic [7:0] wbuf [8];
  logic go_col, go_xfer, xfer_end, ap_close;
  logic [4:0] edge_lim;

  assign BANK_OPEN = open_reg;

  // One tracker per bank
  for (genvar b = 0; b < 8; b++) begin : g_bank
    always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
        open_reg[b] <= 1'b0;
        rp_reg[b] <= 8'h00;
        row_reg[b] <= 16'h0000;
      end else if (ap_close && bank_reg == 3'(b)) begin
        open_reg[b] <= 1'b0;
        rp_reg[b] <= RP;
      end else if (ck_rise && cmd_c == CMD_PRE &&
                   (ba_c == 3'(b) || ad_c[`DDRB_AP_BIT])) begin
        open_reg[b] <= 1'b0;
        rp_reg[b] <= RP; // Restarts even if idle
      end else if (ck_rise && cmd_c == CMD_ACT && ba_c == 3'(b) &&
                   !open_reg[b] && rp_reg[b] == 8'h00) begin
        open_reg[b] <= 1'b1; // Held until a precharge
        row_reg[b] <= ad_c;
      end else if (ck_rise && rp_reg[b] != 8'h00) begin
        rp_reg[b] <= rp_reg[b] - 8'h01;
      end
    end
  end

  // Mode register zero, burst length field only
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      mr_bl_reg <= `DDRB_MR_BL_FIX8;
    end else if (ck_rise && cmd_c == CMD_MRS && ba_c == 3'h0) begin
      mr_bl_reg <= ad_c[`DDRB_MR_BL_HI:`DDRB_MR_BL_LO];
    end
  end

  // Column commands only start when the engine is free, so a
  // transfer in flight on one bank is never cut short
  assign go_col = ck_rise && st_reg == DS_IDLE && open_reg[ba_c] &&
                  (cmd_c == CMD_RD || cmd_c == CMD_WR);
  assign go_xfer = st_reg == DS_WAIT && ck_rise && lat_reg == 6'h01;
  assign edge_lim = is_wr_reg ? 5'(beats_reg) + `DDRB_WR_SLACK :
                    5'(beats_reg);
  // Fixed window: missing or extra strobes cannot stall it
  assign xfer_end = st_reg == DS_XFER && ck_edge && edge_reg == edge_lim;
  assign ap_close = st_reg == DS_DONE && ap_reg;

  // Burst engine
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      st_reg <= DS_IDLE;
      is_wr_reg <= 1'b0;
      ap_reg <= 1'b0;
      beats_reg <= `DDRB_BEATS8;
      bank_reg <= 3'h0;
      idx_reg <= '0;
      lat_reg <= 6'h00;
    end else begin
      case (st_reg)
        DS_IDLE: begin
          if (go_col) begin
            st_reg <= DS_WAIT;
            is_wr_reg <= cmd_c == CMD_WR;
            ap_reg <= ad_c[`DDRB_AP_BIT];
            bank_reg <= ba_c;
            // Select bit picks length per command
            beats_reg <= ddrb_bl8(mr_bl_reg, ad_c[`DDRB_BLSEL_BIT]) ?
                         `DDRB_BEATS8 : `DDRB_BEATS4;
            // Column index leaves the select bit out
            idx_reg <= {ba_c, row_reg[ba_c][IDX_BITS-1:0],
                        ad_c[`DDRB_COL_SEL_BIT]};
            lat_reg <= (cmd_c == CMD_WR) ? WL : RL;
          end
        end
        DS_WAIT: begin
          if (go_xfer) begin
            st_reg <= DS_XFER;
          end else if (ck_rise) begin
            lat_reg <= lat_reg - 6'h01;
          end
        end
        DS_XFER: begin
          if (xfer_end) begin
            st_reg <= DS_DONE;
          end
        end
        DS_DONE: begin
          st_reg <= DS_IDLE;
        end
        default: begin
          st_reg <= DS_IDLE;
        end
      endcase
    end
  end

  // Link clock edges seen since the first beat
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      edge_reg <= 5'h00;
    end else if (go_xfer) begin
      edge_reg <= 5'h01;
    end else if (st_reg == DS_XFER && ck_edge) begin
      edge_reg <= edge_reg + 5'h01;
    end
  end

  // Read drive: one beat per link clock edge
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      LINK.dev_dq_o <= 8'h00;
      LINK.dev_dq_oe_n <= 1'b1;
      LINK.dev_dqs_o <= 1'b0;
      LINK.dev_dqs_oe_n <= 1'b1;
    end else if (is_wr_reg || st_reg == DS_IDLE || xfer_end) begin
      LINK.dev_dq_oe_n <= 1'b1;
      LINK.dev_dqs_oe_n <= 1'b1;
      LINK.dev_dqs_o <= 1'b0;
    end else if (go_xfer) begin
      LINK.dev_dq_oe_n <= 1'b0; // First beat at read latency
      LINK.dev_dq_o <= mem[{idx_reg, 3'h0}];
      LINK.dev_dqs_o <= 1'b1;
    end else if (st_reg == DS_WAIT) begin
      LINK.dev_dqs_oe_n <= 1'b0; // Preamble holds strobe low
      LINK.dev_dqs_o <= 1'b0;
    end else if (st_reg == DS_XFER && ck_edge &&
                 edge_reg < 5'(beats_reg)) begin
      // Chopped burst stops after four beats
      LINK.dev_dq_o <= mem[{idx_reg, edge_reg[2:0]}];
      LINK.dev_dqs_o <= !LINK.dev_dqs_o;
    end
  end

  // Write capture on each strobe edge, early edges included
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      wcnt_reg <= 4'h0;
    end else if (go_col) begin
      wcnt_reg <= 4'h0;
    end else if (is_wr_reg && dqs_edge && wcnt_reg < beats_reg &&
                 (st_reg == DS_WAIT || st_reg == DS_XFER)) begin
      wbuf[wcnt_reg[2:0]] <= dw_q[7:0]; // Bad timing spoils data only
      wcnt_reg <= wcnt_reg + 4'h1;
    end
  end

  // Commit captured beats to the addressed burst only
  always_ff @(posedge CLK_SYS) begin
    if (st_reg == DS_DONE && is_wr_reg) begin
      for (int k = 0; k < 8; k++) begin
        if (4'(k) < wcnt_reg) begin
          mem[{idx_reg, 3'(k)}] <= wbuf[k];
        end
      end
    end
  end
endmodule : ddrb_dev_end

// >>> verilog/ddrb_ctl_end.sv
// Controller end: makes the link clock, sequences init and commands.
// Assumes one user request at a time on a valid/ready handshake.
`timescale 1ns/10ps
`include "ddrb_defines.svh"
module ddrb_ctl_end #(
  parameter int CL = 5,
  parameter int AL = 0,
  parameter int CWL = 5,
  parameter int RP_CK = 4,
  parameter logic [1:0] BL_MODE = `DDRB_MR_BL_OTF,
  parameter int TMO_EDGES = 64
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  input wire logic REINIT,
  // Link to the memory
  ddrb_link_if.ctl LINK,
  // User request
  input wire logic REQ_VALID,
  input wire ddrb_pkg::ddrb_cmd_e REQ_CMD,
  input wire logic [2:0] REQ_BANK,
  input wire logic [15:0] REQ_ADDR,
  input wire logic [63:0] REQ_WDATA,
  output logic REQ_READY,
  output logic REQ_ERR,
  // Read return
  output logic [63:0] RD_DATA,
  output logic RD_VALID
);
  import ddrb_pkg::*;
  localparam logic [7:0] HALF = 8'(`DDRB_CK_HALF_CYC);
  localparam logic [5:0] RL = 6'(AL + CL);
  localparam logic [5:0] WL = 6'(AL + CWL);
  localparam logic [7:0] RP = 8'(RP_CK + 1);
  localparam logic [7:0] TMO = 8'(TMO_EDGES);

  logic [8:0] dw_q, dw_chg;
  logic [7:0] div_reg, tmo_reg;
  logic ck_reg, tick, rise_tick, fall_tick;
  ddrb_ctl_e st_reg;
  logic [1:0] init_reg;
  logic on_bus_reg, is_wr_reg, legal, accept, launch, send_end;
  ddrb_cmd_e pcmd_reg, cmd_reg;
  logic [2:0] pbank_reg, ba_reg;
  logic [15:0] paddr_reg, addr_reg;
  logic [63:0] wdata_reg;
  logic [3:0] beats_reg, edge_reg, rcnt_reg, gap_reg;
  logic [5:0] lat_reg;
  logic [7:0] open_reg;
  logic [7:0] rp_reg [8];
  logic wr_start, wr_end, rd_end;

  ddrb_sync3 #(.W(9)) u_rd_sync (
    .clk(CLK_SYS),
    .rst_n(RSTN),
    .d({LINK.dqs, LINK.dq}),
    .q(dw_q),
    .chg(dw_chg)
  );

  // Link clock divider; the link clock is a register output
  assign tick = div_reg == HALF - 8'h01;
  assign rise_tick = tick && !ck_reg;
  assign fall_tick = tick && ck_reg;
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN) begin
      div_reg <= 8'h00;
      ck_reg <= 1'b0;
    end else if (tick) begin
      div_reg <= 8'h00;
      ck_reg <= !ck_reg;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  assign LINK.ck = ck_reg;
  assign LINK.cmd = cmd_reg;
  assign LINK.bank_select_lines = ba_reg;
  assign LINK.row_address_lines = addr_reg;

  // Refuse activate on open bank and column access on idle bank
  always_comb begin
    case (REQ_CMD)
      CMD_ACT: legal = !open_reg[REQ_BANK];
      CMD_RD, CMD_WR: legal = open_reg[REQ_BANK];
      default: legal = 1'b1;
    endcase
  end
  assign accept = st_reg == CS_IDLE && REQ_VALID && REQ_READY;
  // Activate held back until the precharge period ends
  assign launch = st_reg == CS_SEND && fall_tick && !on_bus_reg &&
                  !(pcmd_reg == CMD_ACT && rp_reg[pbank_reg] != 8'h00);
  assign send_end = st_reg == CS_SEND && fall_tick && on_bus_reg;
  assign wr_start = st_reg == CS_DATA && is_wr_reg && rise_tick &&
                    edge_reg == 4'h0 && lat_reg == 6'h01;
  assign wr_end = st_reg == CS_DATA && is_wr_reg && tick &&
                  edge_reg != 4'h0 && edge_reg == beats_reg;
  assign rd_end = st_reg == CS_DATA && !is_wr_reg &&
                  ((dw_chg[8] && rcnt_reg == beats_reg - 4'h1) ||
                   tmo_reg == TMO);

  // Sequencer and command bus
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || REINIT) begin
      st_reg <= CS_INIT; // Re-initialisation; the link clock divider keeps running
      init_reg <= 2'h0;
      on_bus_reg <= 1'b0;
      cmd_reg <= CMD_NOP;
      ba_reg <= 3'h0;
      addr_reg <= 16'h0000;
      pcmd_reg <= CMD_NOP;
      pbank_reg <= 3'h0;
      paddr_reg <= 16'h0000;
      REQ_READY <= 1'b0;
      REQ_ERR <= 1'b0;
      gap_reg <= 4'h0;
    end else begin
      REQ_ERR <= accept && !legal;
      REQ_READY <= st_reg == CS_IDLE && !(accept && legal);
      case (st_reg)
        CS_INIT: begin
          st_reg <= CS_SEND;
          pbank_reg <= 3'h0;
          pcmd_reg <= (init_reg == 2'h0) ? CMD_PRE : CMD_MRS;
          // All-bank precharge first, then the burst length mode
          paddr_reg <= (init_reg == 2'h0) ?
                       16'h0001 << `DDRB_AP_BIT : 16'(BL_MODE);
        end
        CS_IDLE: begin
          if (accept && legal) begin
            st_reg <= CS_SEND;
            pcmd_reg <= REQ_CMD;
            pbank_reg <= REQ_BANK; // Bank and row driven as given
            paddr_reg <= REQ_ADDR;
          end
        end
        CS_SEND: begin
          if (launch) begin
            cmd_reg <= pcmd_reg;
            ba_reg <= pbank_reg;
            addr_reg <= paddr_reg;
            on_bus_reg <= 1'b1;
          end else if (send_end) begin
            cmd_reg <= CMD_NOP;
            on_bus_reg <= 1'b0;
            if (pcmd_reg == CMD_RD || pcmd_reg == CMD_WR) begin
              st_reg <= CS_DATA;
            end else if (init_reg == 2'h0) begin
              init_reg <= 2'h1;
              st_reg <= CS_INIT;
            end else begin
              init_reg <= 2'h2;
              st_reg <= CS_IDLE;
            end
          end
        end
        CS_DATA: begin
          gap_reg <= `DDRB_CCD_CK;
          if (wr_end || rd_end) begin
            st_reg <= CS_GAP;
          end
        end
        CS_GAP: begin
          // Column spacing and room for the memory to finish
          if (rise_tick) begin
            gap_reg <= gap_reg - 4'h1;
          end
          if (gap_reg == 4'h0) begin
            st_reg <= CS_IDLE;
          end
        end
        default: begin
          st_reg <= CS_INIT;
        end
      endcase
    end
  end

  // Own copy of bank state, counted in link cycles
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || REINIT) begin
      open_reg <= 8'h00;
      for (int b = 0; b < 8; b++) begin
        rp_reg[b] <= 8'h00;
      end
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (launch && pcmd_reg == CMD_ACT && pbank_reg == 3'(b)) begin
          open_reg[b] <= 1'b1;
        end else if (launch && pcmd_reg == CMD_PRE &&
                     (pbank_reg == 3'(b) || paddr_reg[`DDRB_AP_BIT])) begin
          open_reg[b] <= 1'b0;
          rp_reg[b] <= RP;
        end else if ((wr_end || rd_end) && pbank_reg == 3'(b) &&
                     paddr_reg[`DDRB_AP_BIT]) begin
          open_reg[b] <= 1'b0; // Memory closes later, so add margin
          rp_reg[b] <= RP + `DDRB_AP_MARGIN;
        end else if (rise_tick && rp_reg[b] != 8'h00) begin
          rp_reg[b] <= rp_reg[b] - 8'h01;
        end
      end
    end
  end

  // Data path: write drive and read capture
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || REINIT) begin
      LINK.ctl_dq_o <= 8'h00;
      LINK.ctl_dq_oe_n <= 1'b1;
      LINK.ctl_dqs_o <= 1'b0;
      LINK.ctl_dqs_oe_n <= 1'b1;
      RD_DATA <= 64'h0000_0000_0000_0000;
      RD_VALID <= 1'b0;
      is_wr_reg <= 1'b0;
      beats_reg <= `DDRB_BEATS8;
      wdata_reg <= 64'h0000_0000_0000_0000;
      lat_reg <= 6'h00;
      edge_reg <= 4'h0;
      rcnt_reg <= 4'h0;
      tmo_reg <= 8'h00;
    end else begin
      RD_VALID <= rd_end && tmo_reg != TMO;
      if (accept && legal) begin
        is_wr_reg <= REQ_CMD == CMD_WR;
        wdata_reg <= REQ_WDATA;
        beats_reg <= ddrb_bl8(BL_MODE, REQ_ADDR[`DDRB_BLSEL_BIT]) ?
                     `DDRB_BEATS8 : `DDRB_BEATS4;
      end
      if (launch && pcmd_reg == CMD_WR) begin
        LINK.ctl_dqs_oe_n <= 1'b0; // Preamble: strobe held low
        LINK.ctl_dqs_o <= 1'b0;
      end
      if (send_end) begin
        lat_reg <= is_wr_reg ? WL : RL;
        edge_reg <= 4'h0;
        rcnt_reg <= 4'h0;
        tmo_reg <= 8'h00;
        RD_DATA <= 64'h0000_0000_0000_0000;
      end else if (wr_start) begin
        LINK.ctl_dq_oe_n <= 1'b0;
        LINK.ctl_dq_o <= wdata_reg[7:0];
        LINK.ctl_dqs_o <= 1'b1;
        edge_reg <= 4'h1;
      end else if (wr_end) begin
        LINK.ctl_dq_oe_n <= 1'b1;
        LINK.ctl_dqs_oe_n <= 1'b1;
        LINK.ctl_dqs_o <= 1'b0;
      end else if (st_reg == CS_DATA && is_wr_reg && tick &&
                   edge_reg != 4'h0) begin
        LINK.ctl_dq_o <= wdata_reg[{edge_reg[2:0], 3'h0} +: 8];
        LINK.ctl_dqs_o <= !LINK.ctl_dqs_o;
        edge_reg <= edge_reg + 4'h1;
      end else if (st_reg == CS_DATA && is_wr_reg && rise_tick) begin
        lat_reg <= lat_reg - 6'h01;
      end else if (st_reg == CS_DATA && !is_wr_reg) begin
        if (tick) begin
          tmo_reg <= tmo_reg + 8'h01;
        end
        if (dw_chg[8] && rcnt_reg < beats_reg) begin
          RD_DATA[{rcnt_reg[2:0], 3'h0} +: 8] <= dw_q[7:0];
          rcnt_reg <= rcnt_reg + 4'h1;
        end
      end
    end
  end
endmodule : ddrb_ctl_end

// >>> sim/ddrb_link_chk.sv
// Concurrent checks on the link wires between controller and memory end.
// Assumes both ends share CLK_SYS and the active-low synchronous RSTN.
`timescale 1ns/10ps
module ddrb_link_chk
  import ddrb_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RSTN,
  // Link wires
  input wire logic ck,
  input wire logic [2:0] cmd,
  input wire logic [2:0] bank_select_lines,
  input wire logic [15:0] row_address_lines,
  input wire logic ctl_dq_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic dqs
);
  logic [3:0] edge_reg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Strobe edges while the memory end drives; saturates to avoid wrap
  always_ff @(posedge CLK_SYS) begin
    if (!RSTN || dev_dq_oe_n) edge_reg <= 4'h0;
    else if ($changed(dqs) && edge_reg != 4'hf) edge_reg <= edge_reg + 4'h1;
  end
  a_addr_on_fall: assert property (
    $changed({cmd, bank_select_lines, row_address_lines}) |-> !ck)
    else $error("command or address moved while link clock high");
  a_ck_high_half: assert property (
    $rose(ck) |-> ck [*8] ##1 !ck)
    else $error("link clock high phase is not eight cycles");
  a_ck_low_half: assert property (
    $fell(ck) |-> !ck [*8])
    else $error("link clock low phase too short");
  a_one_driver: assert property (
    ctl_dq_oe_n || dev_dq_oe_n)
    else $error("both ends drive the data wires");
  a_read_latency: assert property (
    $rose(ck) && cmd == CMD_RD |-> ##[76:92] !dev_dq_oe_n)
    else $error("read data not driven at read latency");
  a_write_latency: assert property (
    $rose(ck) && cmd == CMD_WR |-> ##[72:90] !ctl_dq_oe_n)
    else $error("write data not driven at write latency");
  a_write_no_dev: assert property (
    $rose(ck) && cmd == CMD_WR |-> dev_dq_oe_n [*8])
    else $error("memory end drives data during a write");
  a_beat_count: assert property (
    $rose(dev_dq_oe_n) |-> edge_reg <= 4'h8)
    else $error("memory end sent more than eight strobe edges");
endmodule : ddrb_link_chk

// >>> sim/dram_bank_row_burst_control_bench.sv
// Bench: controller end and memory end joined, driven from the user side.
// Assumes the verilog/ design files are compiled before this one.
`timescale 1ns/10ps
module dram_bank_row_burst_control_bench;
  import ddrb_pkg::*;
  localparam logic [63:0] D8 = 64'h8877_6655_4433_2211;
  localparam logic [63:0] D4 = 64'hffee_ddcc_bbaa_9988;
  logic clk_sys, rstn, reinit, req_valid, req_ready, req_err, rd_valid, e;
  ddrb_cmd_e req_cmd;
  logic [2:0] req_bank;
  logic [15:0] req_addr;
  logic [63:0] req_wdata, rd_data, r;
  logic [7:0] bank_open;
  int n_fail, num_checks;
  ddrb_link_if link ();
  ddrb_ctl_end i_ddrb_ctl_end (.CLK_SYS(clk_sys), .RSTN(rstn),
    .REINIT(reinit), .LINK(link), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
    .REQ_BANK(req_bank), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
    .REQ_READY(req_ready), .REQ_ERR(req_err), .RD_DATA(rd_data),
    .RD_VALID(rd_valid));
  ddrb_dev_end i_ddrb_dev_end (.CLK_SYS(clk_sys), .RSTN(rstn),
    .LINK(link), .BANK_OPEN(bank_open));
  ddrb_link_chk i_ddrb_link_chk (.CLK_SYS(clk_sys), .RSTN(rstn),
    .ck(link.ck), .cmd(link.cmd), .bank_select_lines(link.bank_select_lines),
    .row_address_lines(link.row_address_lines), .dqs(link.dqs),
    .ctl_dq_oe_n(link.ctl_dq_oe_n), .dev_dq_oe_n(link.dev_dq_oe_n));
  // System clock, 10 ns
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One user request; error flag and read word come back
  task automatic req(input ddrb_cmd_e c, input logic [2:0] b,
    input logic [15:0] a, input logic [63:0] w, output logic err,
    output logic [63:0] rd);
    int n;
    err = 1'b0;
    rd = 64'h0;
    n = 0;
    do @(negedge clk_sys); while (req_ready !== 1'b1 && ++n < 3000);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_wdata <= w;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    repeat (2) begin
      @(negedge clk_sys);
      err = err | req_err;
    end
    if (c == CMD_RD && err !== 1'b1) begin
      n = 0;
      do @(negedge clk_sys); while (rd_valid !== 1'b1 && ++n < 3000);
      rd = rd_data;
    end
  endtask : req
  // Bank status follows the link with sync lag, so poll it bounded
  task automatic wait_open(input int b, input logic v);
    int n;
    n = 0;
    do @(negedge clk_sys); while (bank_open[b] !== v && ++n < 400);
    chk({63'h0, bank_open[b]}, {63'h0, v});
  endtask : wait_open
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
  // Test sequence
  initial begin
    {rstn, reinit, req_valid, req_bank, req_addr, req_wdata} = '0;
    req_cmd = CMD_NOP;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    req(CMD_ACT, 3'h1, 16'h0000, 64'h0, e, r);
    wait_open(1, 1'b1);
    req(CMD_WR, 3'h1, 16'h1000, D8, e, r);
    req(CMD_RD, 3'h1, 16'h1000, 64'h0, e, r);
    chk(r, D8);
    req(CMD_WR, 3'h1, 16'h1008, D8, e, r);
    req(CMD_WR, 3'h1, 16'h0008, D4, e, r);
    req(CMD_RD, 3'h1, 16'h1008, 64'h0, e, r);
    chk(r, {D8[63:32], D4[31:0]});
    req(CMD_RD, 3'h1, 16'h0008, 64'h0, e, r);
    chk(r, {32'h0, D4[31:0]});
    $display("test bursts done");
    req(CMD_ACT, 3'h1, 16'h0001, 64'h0, e, r);
    chk({63'h0, e}, 64'h1);
    req(CMD_RD, 3'h4, 16'h1000, 64'h0, e, r);
    chk({63'h0, e}, 64'h1);
    $display("test refusals done");
    req(CMD_ACT, 3'h2, 16'h0000, 64'h0, e, r);
    wait_open(2, 1'b1);
    req(CMD_PRE, 3'h1, 16'h0000, 64'h0, e, r);
    wait_open(1, 1'b0);
    chk({63'h0, bank_open[2]}, 64'h1);
    req(CMD_PRE, 3'h1, 16'h0000, 64'h0, e, r);
    chk({63'h0, e}, 64'h0);
    req(CMD_ACT, 3'h1, 16'h0000, 64'h0, e, r);
    wait_open(1, 1'b1);
    $display("test precharge done");
    req(CMD_WR, 3'h2, 16'h0400, D4, e, r);
    req(CMD_RD, 3'h1, 16'h1000, 64'h0, e, r);
    chk(r, D8);
    wait_open(2, 1'b0);
    req(CMD_ACT, 3'h2, 16'h0000, 64'h0, e, r);
    req(CMD_RD, 3'h2, 16'h0000, 64'h0, e, r);
    chk(r, {32'h0, D4[31:0]});
    $display("test autoprecharge done");
    req(CMD_PRE, 3'h0, 16'h0400, 64'h0, e, r);
    wait_open(1, 1'b0);
    chk({56'h0, bank_open}, 64'h0);
    // Restart just after a link clock fall, so the bus settles while low
    @(negedge link.ck);
    reinit <= 1'b1;
    @(posedge clk_sys);
    reinit <= 1'b0;
    req(CMD_ACT, 3'h1, 16'h0000, 64'h0, e, r);
    req(CMD_RD, 3'h1, 16'h1000, 64'h0, e, r);
    chk(r, D8);
    $display("test restart done");
    summarize();
  end
endmodule : dram_bank_row_burst_control_bench
